/* isc_fb_div.sv */
// Dual-modulus prescaler with swallow and main counters
`timescale 1ns/10ps
module isc_fb_div
    import isc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic vco_edge_i,
    input wire logic presc_high_i,
    input wire logic [A_W-1:0] a_val_i,
    input wire logic [B_W-1:0] b_val_i,
    output logic modulus_o,
    output logic fb_pulse_o
);

    typedef struct packed {
        logic [P_W-1:0] pre_cnt;
        logic [A_W-1:0] a_cnt;
        logic [B_W-1:0] b_cnt;
        logic fb_pulse;
    } isc_fb_state_t;

    isc_fb_state_t s;
    isc_fb_state_t next_s;
    logic [P_W-1:0] p_val;
    logic swallow;
    logic [P_W-1:0] pre_last;
    logic [B_W-1:0] b_last;

    // ****************************************
    // Divide chain
    // ****************************************
    always_comb
    begin
        next_s = s;
        next_s.fb_pulse = 1'b0;
        // Prescaler modulus P of 16 or 19
        p_val = presc_high_i ? P_HIGH : P_LOW;
        // Swallow phase runs at P+1 for A cycles
        swallow = (s.a_cnt < a_val_i);
        pre_last = swallow ? p_val : p_val - 5'h01;
        b_last = (b_val_i == 12'h000) ? 12'h000 : b_val_i - 12'h001;
        if (vco_edge_i)
        begin
            if (s.pre_cnt >= pre_last)
            begin
                next_s.pre_cnt = 5'h00;
                if (s.b_cnt >= b_last)
                begin
                    next_s.b_cnt = 12'h000;
                    next_s.a_cnt = 5'h00;
                    next_s.fb_pulse = 1'b1;
                end
                else
                begin
                    next_s.b_cnt = s.b_cnt + 12'h001;
                    if (swallow)
                    begin
                        next_s.a_cnt = s.a_cnt + 5'h01;
                    end
                end
            end
            else
            begin
                next_s.pre_cnt = s.pre_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign modulus_o = swallow;
    assign fb_pulse_o = s.fb_pulse;

endmodule

/* isc_pkg.sv */
// Constants, register map and types for the integer-N synthesizer control block
package isc_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REF_W = 10;
    localparam int A_W = 5;
    localparam int B_W = 12;
    localparam int N_W = 17;
    localparam int P_W = 5;
    localparam int PUMP_W = 3;
    localparam int SWING_W = 2;
    localparam int BAND_W = 5;
    localparam int AGE_W = 4;
    localparam int STEP_W = 3;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] REFDIV_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] FBDIV_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0c;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CTRL_VCO_SEL_BIT = 0;
    localparam int CTRL_PRESC_BIT = 1;
    localparam int CTRL_SWING_LSB = 2;
    localparam int CTRL_PUMP_LSB = 4;
    localparam int CTRL_MUTE_BIT = 7;
    localparam int CTRL_ALGO_BIT = 8;
    localparam int CTRL_AUTO_BIT = 9;
    localparam int CTRL_TRIG_BIT = 10;
    localparam int REFDIV_LSB = 0;
    localparam int FBDIV_A_LSB = 0;
    localparam int FBDIV_B_LSB = 16;
    localparam int STATUS_LOCK_BIT = 0;
    localparam int STATUS_BUSY_BIT = 1;
    localparam int STATUS_BAND_LSB = 2;
    localparam int STATUS_TRIG_BIT = 7;

    // ****************************************
    // Reset values and fixed codes
    // ****************************************
    localparam logic [REF_W-1:0] REFDIV_RST = 10'h002;
    localparam logic [A_W-1:0] A_RST = 5'h00;
    localparam logic [B_W-1:0] B_RST = 12'h010;
    localparam logic [PUMP_W-1:0] PUMP_RST = 3'h0;
    localparam logic [SWING_W-1:0] SWING_RST = 2'h3;
    localparam logic [P_W-1:0] P_LOW = 5'h10;
    localparam logic [P_W-1:0] P_HIGH = 5'h13;
    localparam logic [BAND_W-1:0] BAND_START = 5'h10;
    localparam logic [STEP_W-1:0] SEARCH_FIRST_BIT = 3'h4;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CORE_PERIOD_PS = 4000;
    localparam int LOCK_DELAY_PS = 5000;
    localparam int LOCK_WIN_RAW = LOCK_DELAY_PS / CORE_PERIOD_PS;
    localparam logic [AGE_W-1:0] LOCK_WIN_CYC = (LOCK_WIN_RAW < 1) ? 4'h1 : AGE_W'(LOCK_WIN_RAW);
    localparam int CAL_PERIODS = 7;

    // ****************************************
    // Calibration sequencer states
    // ****************************************
    typedef enum logic [3:0]
    {
        CAL_IDLE = 4'b0001,
        CAL_SETTLE = 4'b0010,
        CAL_SEARCH = 4'b0100,
        CAL_FINISH = 4'b1000
    } isc_cal_state_t;

endpackage

/* isc_pll_model.sv */
// Stand-in for reference, oscillator and phase detector around the block
`timescale 1ns/10ps
module isc_pll_model
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [1:0] skew_i,
    output logic ref_o,
    output logic vco_edge_o,
    output logic up_o,
    output logic dn_o
);
    logic [3:0] phase;
    logic [3:0] lag;
    always_ff @(posedge clk_i)
    begin
        phase <= rstn_i ? phase + 4'h1 : 4'h0;
    end
    assign lag = phase - {2'h0, skew_i};
    assign ref_o = phase[0];
    assign vco_edge_o = phase[0];
    // Skew above one cycle reads as unlock
    assign up_o = (phase[3:2] == 2'h1);
    assign dn_o = (lag[3:2] == 2'h1);
endmodule

/* isc_synth_ctrl.sv */
// Integer-N synthesizer control: dividers, lock detect, mute and sub-band calibration
`timescale 1ns/10ps

// Functional notes
// - Reference input divided by 10-bit ratio R gives the comparison clock.
// - Prescaler divides oscillator by P or P+1; P is 16 or 19.
// - Swallow counter A (5 bits), main counter B (12 bits): N = B*P+A.
// - Swallow counter accepts every value 0 to 31.
// - N spans 256..65551 for P=16 and 361..77836 for P=19.
// - Lock high while up/down rising edges differ under about 5 ns.
// - Mute-until-lock disables RF, LO buffer, mixer and IF until lock.
// - 3-bit pump code k selects (k+1) times minimum current.
// - During calibration pump inhibited, pump and tuning pins at calibration voltage.
// - Each of two oscillators offers 32 sub-bands chosen by calibration.
// - Calibration starts when range search trigger goes 0 to 1.
// - Sub-band nearest N*Fref/R chosen with calibration voltage applied.
// - Calibration lasts about seven comparison periods, then trigger self-clears.
// - Algorithm select 0 uses midpoint voltage; 1 uses temperature-robust algorithm.
// - With auto recalibration on, lock falling edge restarts calibration.
// - Two-bit swing setting selects one of four oscillator levels.
// - Selected oscillator output is divided by two for the LO.
module isc_synth_ctrl
    import isc_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [DATA_W-1:0] RDATA_O,
    input wire logic REF_I,
    input wire logic VCO_A_EDGE_I,
    input wire logic VCO_B_EDGE_I,
    input wire logic UP_I,
    input wire logic DN_I,
    output logic CMP_PULSE_O,
    output logic FB_PULSE_O,
    output logic MODULUS_O,
    output logic LOCK_O,
    output logic [PUMP_W-1:0] PUMP_CURRENT_CODE_O,
    output logic [PUMP_W:0] PUMP_MULT_O,
    output logic PUMP_ENABLE_O,
    output logic FORCE_CAL_VOLTAGE_O,
    output logic CAL_MIDPOINT_O,
    output logic CAL_ROBUST_O,
    output logic CAL_BUSY_O,
    output logic VCO_SEL_O,
    output logic [BAND_W-1:0] SUBBAND_O,
    output logic [SWING_W-1:0] SWING_LEVEL_O,
    output logic LO_DIV2_O,
    output logic RF_OUT_EN_O,
    output logic LO_BUF_EN_O,
    output logic MIXER_EN_O,
    output logic IF_AMP_EN_O
);

    typedef struct packed {
        logic vco_sel;
        logic presc_high;
        logic [SWING_W-1:0] swing;
        logic [PUMP_W-1:0] pump_code;
        logic [PUMP_W:0] pump_mult;
        logic mute_en;
        logic algo;
        logic auto_en;
        logic range_search_trigger;
        logic [REF_W-1:0] rdiv;
        logic [A_W-1:0] a_val;
        logic [B_W-1:0] b_val;
        logic [DATA_W-1:0] rdata;
        logic ref_prev;
        logic [REF_W-1:0] ref_cnt;
        logic cmp_pulse;
        logic up_prev;
        logic dn_prev;
        logic pend_up;
        logic pend_dn;
        logic [AGE_W-1:0] age;
        logic lock;
        logic lock_prev;
        isc_cal_state_t cal_state;
        logic [STEP_W-1:0] step;
        logic [BAND_W-1:0] band;
        logic [BAND_W-1:0] best_band;
        logic [N_W-1:0] best_err;
        logic [N_W-1:0] edge_cnt;
        logic lo_div;
    } isc_state_t;

    isc_state_t s;
    isc_state_t next_s;
    logic vco_edge;
    logic [N_W-1:0] n_target;
    logic [N_W-1:0] err;
    logic [BAND_W-1:0] new_band;
    logic [REF_W-1:0] ref_last;
    logic wr_ctrl;
    logic sw_trigger;
    logic auto_start;
    logic up_rise;
    logic dn_rise;

    // Distance between measured and wanted edge count
    function automatic logic [N_W-1:0] abs_diff(input logic [N_W-1:0] x, input logic [N_W-1:0] y);
        abs_diff = (x > y) ? x - y : y - x;
    endfunction

    // ****************************************
    // Feedback divider
    // ****************************************
    assign vco_edge = s.vco_sel ? VCO_B_EDGE_I : VCO_A_EDGE_I;

    isc_fb_div u_fb_div
    (
        .clk_i(CORE_CLK_I),
        .rstn_i(RSTN_I),
        .vco_edge_i(vco_edge),
        .presc_high_i(s.presc_high),
        .a_val_i(s.a_val),
        .b_val_i(s.b_val),
        .modulus_o(MODULUS_O),
        .fb_pulse_o(FB_PULSE_O)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb
    begin
        next_s = s;
        next_s.rdata = '0;
        next_s.cmp_pulse = 1'b0;
        n_target = {5'h00, s.b_val} * {12'h000, (s.presc_high ? P_HIGH : P_LOW)};
        n_target = n_target + {12'h000, s.a_val};
        err = abs_diff(s.edge_cnt, n_target);
        new_band = s.band;
        wr_ctrl = WR_I && (ADDR_I == CTRL_OFS);
        sw_trigger = wr_ctrl && WDATA_I[CTRL_TRIG_BIT];
        auto_start = s.auto_en && s.lock_prev && !s.lock && (s.cal_state == CAL_IDLE);
        up_rise = UP_I && !s.up_prev;
        dn_rise = DN_I && !s.dn_prev;
        ref_last = (s.rdiv == 10'h000) ? 10'h000 : s.rdiv - 10'h001;

        // Register writes
        if (wr_ctrl)
        begin
            next_s.vco_sel = WDATA_I[CTRL_VCO_SEL_BIT];
            next_s.presc_high = WDATA_I[CTRL_PRESC_BIT];
            next_s.swing = WDATA_I[CTRL_SWING_LSB +: SWING_W];
            next_s.pump_code = WDATA_I[CTRL_PUMP_LSB +: PUMP_W];
            next_s.pump_mult = {1'b0, WDATA_I[CTRL_PUMP_LSB +: PUMP_W]} + 4'h1;
            next_s.mute_en = WDATA_I[CTRL_MUTE_BIT];
            next_s.algo = WDATA_I[CTRL_ALGO_BIT];
            next_s.auto_en = WDATA_I[CTRL_AUTO_BIT];
        end
        if (WR_I && (ADDR_I == REFDIV_OFS))
        begin
            next_s.rdiv = WDATA_I[REFDIV_LSB +: REF_W];
        end
        if (WR_I && (ADDR_I == FBDIV_OFS))
        begin
            next_s.a_val = WDATA_I[FBDIV_A_LSB +: A_W];
            next_s.b_val = WDATA_I[FBDIV_B_LSB +: B_W];
        end

        // Register reads, data valid in the following cycle
        if (RD_I)
        begin
            unique case (ADDR_I)
                CTRL_OFS:
                begin
                    next_s.rdata[CTRL_VCO_SEL_BIT] = s.vco_sel;
                    next_s.rdata[CTRL_PRESC_BIT] = s.presc_high;
                    next_s.rdata[CTRL_SWING_LSB +: SWING_W] = s.swing;
                    next_s.rdata[CTRL_PUMP_LSB +: PUMP_W] = s.pump_code;
                    next_s.rdata[CTRL_MUTE_BIT] = s.mute_en;
                    next_s.rdata[CTRL_ALGO_BIT] = s.algo;
                    next_s.rdata[CTRL_AUTO_BIT] = s.auto_en;
                    next_s.rdata[CTRL_TRIG_BIT] = s.range_search_trigger;
                end
                REFDIV_OFS:
                begin
                    next_s.rdata[REFDIV_LSB +: REF_W] = s.rdiv;
                end
                FBDIV_OFS:
                begin
                    next_s.rdata[FBDIV_A_LSB +: A_W] = s.a_val;
                    next_s.rdata[FBDIV_B_LSB +: B_W] = s.b_val;
                end
                STATUS_OFS:
                begin
                    next_s.rdata[STATUS_LOCK_BIT] = s.lock;
                    next_s.rdata[STATUS_BUSY_BIT] = (s.cal_state != CAL_IDLE);
                    next_s.rdata[STATUS_BAND_LSB +: BAND_W] = s.band;
                    next_s.rdata[STATUS_TRIG_BIT] = s.range_search_trigger;
                end
                default:
                begin
                    next_s.rdata = '0;
                end
            endcase
        end

        // ****************************************
        // Reference divider
        // ****************************************
        next_s.ref_prev = REF_I;
        if (REF_I && !s.ref_prev)
        begin
            if (s.ref_cnt >= ref_last)
            begin
                next_s.ref_cnt = 10'h000;
                next_s.cmp_pulse = 1'b1;
            end
            else
            begin
                next_s.ref_cnt = s.ref_cnt + 10'h001;
            end
        end

        // Oscillator edges per comparison period
        if (s.cmp_pulse)
        begin
            next_s.edge_cnt = {16'h0000, vco_edge};
        end
        else if (vco_edge && (s.edge_cnt != '1))
        begin
            next_s.edge_cnt = s.edge_cnt + 17'h00001;
        end

        if (vco_edge)
        begin
            next_s.lo_div = !s.lo_div;
        end

        // ****************************************
        // Lock detector
        // ****************************************
        next_s.up_prev = UP_I;
        next_s.dn_prev = DN_I;
        next_s.lock_prev = s.lock;
        if (up_rise && dn_rise)
        begin
            next_s.lock = 1'b1;
            next_s.pend_up = 1'b0;
            next_s.pend_dn = 1'b0;
        end
        else if ((s.pend_up && dn_rise) || (s.pend_dn && up_rise))
        begin
            next_s.lock = 1'b1;
            next_s.pend_up = 1'b0;
            next_s.pend_dn = 1'b0;
        end
        else if (up_rise || dn_rise)
        begin
            next_s.pend_up = up_rise;
            next_s.pend_dn = dn_rise;
            next_s.age = '0;
        end
        else if (s.pend_up || s.pend_dn)
        begin
            if (s.age + 4'h1 >= LOCK_WIN_CYC)
            begin
                next_s.lock = 1'b0;
                next_s.pend_up = 1'b0;
                next_s.pend_dn = 1'b0;
            end
            else
            begin
                next_s.age = s.age + 4'h1;
            end
        end

        // ****************************************
        // Sub-band calibration
        // ****************************************
        unique case (s.cal_state)
            CAL_IDLE:
            begin
                // start on trigger 0 to 1
                if ((sw_trigger && !s.range_search_trigger) || auto_start)
                begin
                    next_s.range_search_trigger = 1'b1;
                    next_s.cal_state = CAL_SETTLE;
                    next_s.band = BAND_START;
                    next_s.best_err = '1;
                end
            end
            CAL_SETTLE:
            begin
                // First partial period discarded
                if (s.cmp_pulse)
                begin
                    next_s.cal_state = CAL_SEARCH;
                    next_s.step = SEARCH_FIRST_BIT;
                end
            end
            CAL_SEARCH:
            begin
                if (s.cmp_pulse)
                begin
                    if (err < s.best_err)
                    begin
                        next_s.best_err = err;
                        next_s.best_band = s.band;
                    end
                    if (s.edge_cnt > n_target)
                    begin
                        new_band[s.step] = 1'b0;
                    end
                    if (s.step == 3'h0)
                    begin
                        next_s.cal_state = CAL_FINISH;
                    end
                    else
                    begin
                        new_band[s.step - 3'h1] = 1'b1;
                        next_s.step = s.step - 3'h1;
                    end
                    next_s.band = new_band;
                end
            end
            CAL_FINISH:
            begin
                if (s.cmp_pulse)
                begin
                    if (err >= s.best_err)
                    begin
                        next_s.band = s.best_band;
                    end
                    next_s.range_search_trigger = 1'b0;
                    next_s.cal_state = CAL_IDLE;
                    // Trigger written in the clearing cycle wins and reruns
                    if (sw_trigger)
                    begin
                        next_s.range_search_trigger = 1'b1;
                        next_s.cal_state = CAL_SETTLE;
                        next_s.band = BAND_START;
                        next_s.best_err = '1;
                    end
                end
            end
        endcase
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RSTN_I)
        begin
            s <= '0;
            s.swing <= SWING_RST;
            s.pump_code <= PUMP_RST;
            s.pump_mult <= {1'b0, PUMP_RST} + 4'h1;
            s.rdiv <= REFDIV_RST;
            s.a_val <= A_RST;
            s.b_val <= B_RST;
            s.cal_state <= CAL_IDLE;
            s.band <= BAND_START;
            s.best_band <= BAND_START;
            s.best_err <= '1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign RDATA_O = s.rdata;
    assign CMP_PULSE_O = s.cmp_pulse;
    assign LOCK_O = s.lock;
    assign PUMP_CURRENT_CODE_O = s.pump_code;
    assign PUMP_MULT_O = s.pump_mult;
    assign CAL_BUSY_O = (s.cal_state != CAL_IDLE);
    // pump off, pins held during calibration
    assign PUMP_ENABLE_O = (s.cal_state == CAL_IDLE);
    assign FORCE_CAL_VOLTAGE_O = (s.cal_state != CAL_IDLE);
    assign CAL_MIDPOINT_O = (s.cal_state != CAL_IDLE) && !s.algo;
    assign CAL_ROBUST_O = (s.cal_state != CAL_IDLE) && s.algo;
    assign VCO_SEL_O = s.vco_sel;
    assign SUBBAND_O = s.band;
    assign SWING_LEVEL_O = s.swing;
    assign LO_DIV2_O = s.lo_div;
    assign RF_OUT_EN_O = !(s.mute_en && !s.lock);
    assign LO_BUF_EN_O = !(s.mute_en && !s.lock);
    assign MIXER_EN_O = !(s.mute_en && !s.lock);
    assign IF_AMP_EN_O = !(s.mute_en && !s.lock);

endmodule

/* isc_synth_ctrl_props.sv */
// Concurrent checks on the synthesizer control ports
`timescale 1ns/10ps
module isc_synth_ctrl_props
    import isc_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [DATA_W-1:0] WDATA_I,
    input wire logic WR_I,
    input wire logic UP_I,
    input wire logic DN_I,
    input wire logic LOCK_O,
    input wire logic [PUMP_W-1:0] PUMP_CURRENT_CODE_O,
    input wire logic [PUMP_W:0] PUMP_MULT_O,
    input wire logic PUMP_ENABLE_O,
    input wire logic FORCE_CAL_VOLTAGE_O,
    input wire logic CAL_MIDPOINT_O,
    input wire logic CAL_ROBUST_O,
    input wire logic CAL_BUSY_O,
    input wire logic RF_OUT_EN_O
);
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RSTN_I);
    // ****
    // Port relations
    // ****
    pump_mult_a: assert property (PUMP_MULT_O == {1'b0, PUMP_CURRENT_CODE_O} + 4'h1)
        else $error("pump multiplier wrong");
    cal_pins_a: assert property (CAL_BUSY_O |-> !PUMP_ENABLE_O && FORCE_CAL_VOLTAGE_O)
        else $error("pump not held during calibration");
    pump_back_a: assert property ($fell(CAL_BUSY_O) |-> PUMP_ENABLE_O && !FORCE_CAL_VOLTAGE_O)
        else $error("pump not released after calibration");
    algo_mid_a: assert property (CAL_MIDPOINT_O |-> CAL_BUSY_O && !CAL_ROBUST_O)
        else $error("midpoint voltage outside calibration");
    algo_robust_a: assert property (CAL_ROBUST_O |-> CAL_BUSY_O && !CAL_MIDPOINT_O)
        else $error("robust algorithm outside calibration");
    lock_rise_a: assert property ($rose(UP_I) && $rose(DN_I) |=> LOCK_O)
        else $error("aligned edges gave no lock");
    lock_loss_a: assert property (($rose(UP_I) && !DN_I) ##1 !$rose(DN_I) |-> ##[1:2] !LOCK_O)
        else $error("skewed edges kept lock");
    mute_lock_a: assert property (LOCK_O |-> RF_OUT_EN_O)
        else $error("output muted while locked");
    trig_start_a: assert property (WR_I && ADDR_I == CTRL_OFS && WDATA_I[CTRL_TRIG_BIT]
        && !CAL_BUSY_O |=> CAL_BUSY_O) else $error("trigger did not start calibration");
    cal_len_a: assert property ($rose(CAL_BUSY_O) |-> CAL_BUSY_O[*7])
        else $error("calibration too short");
endmodule
bind isc_synth_ctrl isc_synth_ctrl_props isc_synth_ctrl_props_inst (.*);

/* isc_synth_ctrl_tb.sv */
// Self-checking testbench for the synthesizer control block
`timescale 1ns/10ps
module isc_synth_ctrl_tb
    import isc_pkg::*;
;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata;
    logic [1:0] skew = 2'h3;
    logic refc, vco, up, dn, cmp, fb, lock, pen, fcv, mid, rob, busy, vsel, div2;
    logic rfen, lob, mix, ifa, modu;
    logic [BAND_W-1:0] band;
    logic [PUMP_W-1:0] pcode;
    logic [PUMP_W:0] pmult;
    logic [SWING_W-1:0] swing;
    int bad_count = 0, checked = 0;
    always #2 clk = ~clk;
    isc_synth_ctrl isc_synth_ctrl_inst (.CORE_CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr),
        .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .REF_I(refc),
        .VCO_A_EDGE_I(vco), .VCO_B_EDGE_I(vco), .UP_I(up), .DN_I(dn), .CMP_PULSE_O(cmp),
        .FB_PULSE_O(fb), .MODULUS_O(modu), .LOCK_O(lock), .PUMP_CURRENT_CODE_O(pcode),
        .PUMP_MULT_O(pmult), .PUMP_ENABLE_O(pen), .FORCE_CAL_VOLTAGE_O(fcv),
        .CAL_MIDPOINT_O(mid), .CAL_ROBUST_O(rob), .CAL_BUSY_O(busy), .VCO_SEL_O(vsel),
        .SUBBAND_O(band), .SWING_LEVEL_O(swing), .LO_DIV2_O(div2), .RF_OUT_EN_O(rfen),
        .LO_BUF_EN_O(lob), .MIXER_EN_O(mix), .IF_AMP_EN_O(ifa));
    isc_pll_model isc_pll_model_inst (.clk_i(clk), .rstn_i(rstn), .skew_i(skew),
        .ref_o(refc), .vco_edge_o(vco), .up_o(up), .dn_o(dn));
    // ****
    // Shared tasks
    // ****
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic gap(input bit use_fb, output int n, output int m);
        int k;
        n = 0;
        m = 0;
        k = 0;
        for (int i = 0; i < 4000 && k < 2; i++)
        begin
            @(posedge clk);
            #1;
            if ((use_fb ? fb : cmp) === 1'b1)
            begin
                n = i - n;
                k++;
            end
            m += (k == 1 && modu === 1'b1);
        end
    endtask
    task automatic wait_cal(output int n);
        n = 0;
        for (int i = 0; i < 300 && busy === 1'b1; i++)
        begin
            n += (cmp === 1'b1);
            @(posedge clk);
            #1;
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic t_regs();
        logic [DATA_W-1:0] d;
        logic [ADDR_W-1:0] ad [5] = '{CTRL_OFS, REFDIV_OFS, FBDIV_OFS, STATUS_OFS, 8'h10};
        logic [DATA_W-1:0] ex [5] = '{32'hc, 32'h2, 32'h0010_0000, 32'h40, 32'h0};
        wr_reg(8'h10, 32'hffff_ffff);
        for (int i = 0; i < 5; i++)
        begin
            rd_reg(ad[i], d);
            chk("reg", d, ex[i]);
        end
    endtask
    task automatic t_pump();
        for (int k = 0; k < 8; k++)
        begin
            wr_reg(CTRL_OFS, (k << CTRL_PUMP_LSB) | ((k % 4) << CTRL_SWING_LSB) | (k % 2));
            chk("pump code", pcode, k);
            chk("pump mult", pmult, k + 1);
            chk("swing", swing, k % 4);
            chk("osc sel", vsel, k % 2);
        end
    endtask
    task automatic t_div();
        int p [3] = '{16, 19, 16};
        int b [3] = '{8, 8, 32};
        int a [3] = '{5, 5, 31};
        int n;
        int m;
        for (int i = 0; i < 3; i++)
        begin
            wr_reg(CTRL_OFS, (p[i] == 19) ? 32'h2 : 32'h0);
            wr_reg(FBDIV_OFS, (b[i] << FBDIV_B_LSB) | a[i]);
            gap(1'b1, n, m);
            gap(1'b1, n, m);
            chk("fb gap", n, 2 * (b[i] * p[i] + a[i]));
            chk("swallow span", m, 2 * a[i] * (p[i] + 1));
        end
        wr_reg(REFDIV_OFS, 32'h7);
        gap(1'b0, n, m);
        gap(1'b0, n, m);
        chk("cmp gap", n, 14);
        wr_reg(REFDIV_OFS, 32'h2);
    endtask
    task automatic t_cal();
        int n;
        int t = 0;
        logic [DATA_W-1:0] d;
        wr_reg(CTRL_OFS, 32'h400);
        chk("cal pins", {busy, pen, fcv, mid, rob}, 5'b10110);
        chk("start band", band, BAND_START);
        wait_cal(n);
        chk("cal periods", n, 7);
        chk("pump back", {pen, fcv}, 2'b10);
        rd_reg(STATUS_OFS, d);
        chk("trigger", d[STATUS_TRIG_BIT], 1'b0);
        wr_reg(CTRL_OFS, 32'h500);
        chk("robust", {mid, rob}, 2'b01);
        wait_cal(n);
        for (int i = 0; i < 20; i++)
        begin
            d[0] = div2;
            @(posedge clk);
            #1;
            t += (div2 !== d[0]);
        end
        chk("lo toggles", t, 10);
    endtask
    task automatic t_lock();
        wr_reg(CTRL_OFS, 32'h80);
        skew <= 2'h0;
        repeat (40) @(posedge clk);
        #1;
        chk("lock", lock, 1'b1);
        chk("enables", {rfen, lob, mix, ifa}, 4'hf);
        @(posedge clk);
        skew <= 2'h3;
        repeat (40) @(posedge clk);
        #1;
        chk("unlock", lock, 1'b0);
        chk("muted", {rfen, lob, mix, ifa}, 4'h0);
        wr_reg(CTRL_OFS, 32'h200);
        skew <= 2'h0;
        repeat (40) @(posedge clk);
        skew <= 2'h3;
        for (int i = 0; i < 40 && busy !== 1'b1; i++)
            @(posedge clk);
        #1;
        chk("auto start", busy, 1'b1);
    endtask
    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        t_regs();
        t_pump();
        t_div();
        t_cal();
        t_lock();
        results();
    end
    initial
    begin
        #200000;
        bad_count++;
        results();
    end
endmodule
